// >>> inc/host_pin_mux_pkg.sv
// Purpose : Constants and carriers for the host-port data pin mux
// Assumes : One core clock, active-low asynchronous reset
// Notes   : Shared by the pin mux top and its testbench
//
// Notes on behaviour
// - Data pins go to GPIO or host bus
// - Function latched at reset release, then kept
// - Floating data pins hold last driven level
// - Holders on at reset, software may toggle
// - GPIO function: bits start as inputs
// - Host function: data bus starts as input
// - Host function means multiplexed 8-bit mode
// - Host cycle is two consecutive byte transfers
// - Control pin zero goes to GPIO or strobe
// - Address strobe honoured only in multiplexed mode
package host_pin_mux_pkg;

  // ==========================================================
  // Widths and reset values
  localparam int           DATA_W         = 8;
  localparam logic         HOLD_EN_RST    = 1'b1;
  localparam logic         BOOT_SEL_RST   = 1'b0;
  localparam logic [7:0]   DATA_OE_RST    = 8'h00;
  localparam logic [7:0]   HOLD_VAL_RST   = 8'h00;
  localparam int           GPIO_LSB       = 36;
  localparam int           GPIO_STROBE    = 44;

  // ==========================================================
  // Pin function choice
  typedef enum logic {
    FUNC_GPIO,
    FUNC_HOST
  } pin_func_e;

  // Drive request from one function: value and enable
  typedef struct packed {
    logic [7:0] data_out;
    logic [7:0] data_oe;
    logic       ctl_out;
    logic       ctl_oe;
  } pin_drive_s;

endpackage

// >>> src/bus_holder.sv
// Purpose : Keeper for the host data pins
// Assumes : Drive value and enable come from the caller's selected function
// Notes   : Models the weak keeper as a drive of the last level
`timescale 1ns/1ps
module bus_holder #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_hold_en,
  input  wire logic [WIDTH-1:0] i_drv_val,
  input  wire logic [WIDTH-1:0] i_drv_oe,
  output logic      [WIDTH-1:0] o_keep_val,
  output logic      [WIDTH-1:0] o_keep_oe
);

  logic [WIDTH-1:0] last_q;
  logic [WIDTH-1:0] last_d;

  // ==========================================================
  // Remember the level most recently driven on each pin
  generate
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      assign last_d[b]     = i_drv_oe[b] ? i_drv_val[b] : last_q[b];
      // Keeper acts only while nobody drives the pin
      assign o_keep_oe[b]  = i_hold_en & ~i_drv_oe[b];
    end
  endgenerate

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      last_q <= '0;
    end else begin
      last_q <= last_d;
    end
  end

  assign o_keep_val = last_q;

endmodule

// >>> src/host_port_data_pin_mux.sv
// Purpose : Pin mux for host data pins and host control pin zero
// Assumes : Pins come from outside and are synchronised here
// Notes   : The function choice is frozen at reset release
`timescale 1ns/1ps
module host_port_data_pin_mux (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_b,
  // Boot select strap pin
  input  wire logic       i_boot_select_pin,
  // Holder enable from the external bus control setting
  input  wire logic       i_hold_enable,
  // Data pins, split into three signals
  input  wire logic [7:0] i_host_data_pins,
  output logic      [7:0] o_host_data_pins,
  output logic      [7:0] o_host_data_pins_oe,
  // Control pin zero
  input  wire logic       i_host_control_pin_zero,
  output logic            o_host_control_pin_zero,
  output logic            o_host_control_pin_zero_oe,
  // GPIO side
  input  wire host_pin_mux_pkg::pin_drive_s i_gpio_drive,
  output logic      [7:0] o_parallel_io_bits_high_byte,
  output logic            o_parallel_io_bit_strobe_alt,
  // Host port side
  input  wire host_pin_mux_pkg::pin_drive_s i_host_drive,
  output logic      [7:0] o_host_bus_data,
  output logic            o_host_address_strobe,
  // Status
  output logic            o_host_mode,
  output logic            o_mux_mode,
  output logic            o_hold_active
);

  // ==========================================================
  // Pin synchronisers: first stage feeds only the second
  logic [9:0] sync1_q;
  logic [9:0] sync2_q;
  logic       boot_sync_w;
  logic [7:0] data_sync_w;
  logic       ctl_sync_w;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {i_boot_select_pin, i_host_control_pin_zero,
                  i_host_data_pins};
      sync2_q <= sync1_q;
    end
  end

  assign data_sync_w = sync2_q[7:0];
  assign ctl_sync_w  = sync2_q[8];
  assign boot_sync_w = sync2_q[9];

  // ==========================================================
  // Strap capture. The function register follows a reset-free
  // strap pair while unlocked and freezes once the released reset
  // has passed its own two flops, so a strap that wanders during
  // reset only counts with the value it holds at release.
  logic strap1_q;
  logic strap2_q;
  logic func_q;
  logic locked_q;
  logic rst_s1_q;
  logic rst_s2_q;

  // Strap pair has no reset so it samples during reset
  always_ff @(posedge i_core_clk) begin
    strap1_q <= i_boot_select_pin;
    strap2_q <= strap1_q;
  end

  // Reset release seen as a level in the clock domain
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Follow strap from reset release until locked, then freeze
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      func_q   <= host_pin_mux_pkg::BOOT_SEL_RST;
      locked_q <= 1'b0;
    end else if (!locked_q) begin
      func_q   <= strap2_q;
      locked_q <= rst_s2_q;
    end
  end

  wire host_sel_w = locked_q & (func_q == host_pin_mux_pkg::FUNC_HOST);
  wire gpio_sel_w = ~host_sel_w;

  // ==========================================================
  // Drive selection: unselected function is ignored; before the
  // lock both requests are masked and only the keeper, on from reset, drives the pins.
  wire host_pin_mux_pkg::pin_drive_s sel_drv_w =
    !locked_q  ? '0 :
    host_sel_w ? i_host_drive : i_gpio_drive;

  // ==========================================================
  // Bus holder enable: on at reset, then set by software
  logic hold_en_q;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_en_q <= host_pin_mux_pkg::HOLD_EN_RST;
    end else if (locked_q) begin
      hold_en_q <= i_hold_enable;
    end
  end

  logic [7:0] keep_val_w;
  logic [7:0] keep_oe_w;

  bus_holder #(
    .WIDTH (host_pin_mux_pkg::DATA_W)
  ) u_holder (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_hold_en  (hold_en_q),
    .i_drv_val  (sel_drv_w.data_out),
    .i_drv_oe   (sel_drv_w.data_oe),
    .o_keep_val (keep_val_w),
    .o_keep_oe  (keep_oe_w)
  );

  // ==========================================================
  // Pin outputs: functional drive first, keeper otherwise
  assign o_host_data_pins    = (sel_drv_w.data_out & sel_drv_w.data_oe)
                             | (keep_val_w & keep_oe_w);
  assign o_host_data_pins_oe = sel_drv_w.data_oe | keep_oe_w;
  assign o_host_control_pin_zero    = sel_drv_w.ctl_out;
  // Strobe function is input only, so only GPIO may drive
  assign o_host_control_pin_zero_oe = sel_drv_w.ctl_oe
                                    & gpio_sel_w;

  // ==========================================================
  // Input routing: inactive side reads zero
  assign o_parallel_io_bits_high_byte = gpio_sel_w ? data_sync_w
                                                   : 8'h00;
  assign o_host_bus_data = host_sel_w ? data_sync_w : 8'h00;
  assign o_parallel_io_bit_strobe_alt = gpio_sel_w & ctl_sync_w;
  // Strobe only reaches the host port in multiplexed mode
  assign o_host_address_strobe = host_sel_w & ctl_sync_w;
  // Multiplexed 8-bit mode: byte pairing via identify, outside
  assign o_host_mode   = host_sel_w;
  assign o_mux_mode    = host_sel_w;
  assign o_hold_active = hold_en_q;

  // ==========================================================
  // Checks
  func_stable_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) locked_q |=> $stable(func_q))
    else $error("function changed after lock");
  lock_time_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) $rose(rst_s2_q) |=> locked_q)
    else $error("lock not taken after release");
  lock_keep_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) locked_q |=> locked_q)
    else $error("lock dropped before reset");
  strap_take_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) $rose(locked_q) |-> func_q == $past(strap2_q))
    else $error("strap value not captured");
  gpio_route_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) gpio_sel_w |->
      o_parallel_io_bits_high_byte == data_sync_w && o_host_bus_data == 0)
    else $error("gpio routing wrong");
  host_route_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) host_sel_w |->
      o_host_bus_data == data_sync_w && o_parallel_io_bits_high_byte == 0)
    else $error("host routing wrong");
  ctl_route_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) gpio_sel_w |->
      o_parallel_io_bit_strobe_alt == ctl_sync_w)
    else $error("control pin routing wrong");
  strobe_gate_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) !host_sel_w |-> !o_host_address_strobe)
    else $error("strobe outside host mode");
  strobe_in_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) host_sel_w |-> !o_host_control_pin_zero_oe)
    else $error("strobe pin driven");
  unsel_ignore_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) (host_sel_w && i_host_drive.data_oe == 0
      && !hold_en_q) |-> o_host_data_pins_oe == 0)
    else $error("unselected drive leaked");
  host_oe_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) (host_sel_w && !hold_en_q) |->
      o_host_data_pins_oe == i_host_drive.data_oe)
    else $error("host drive enable not passed");
  hold_keep_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) (hold_en_q && sel_drv_w.data_oe == 0) |->
      o_host_data_pins_oe == 8'hFF && o_host_data_pins == keep_val_w)
    else $error("keeper not holding");
  keep_load_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) 1'b1 |=> ((keep_val_w ^ $past(sel_drv_w.data_out))
      & $past(sel_drv_w.data_oe)) == 8'h00)
    else $error("keeper missed driven level");
  input_start_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) !locked_q |-> sel_drv_w.data_oe == 0)
    else $error("pins driven before lock");
  hold_rst_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) !locked_q |-> hold_en_q)
    else $error("holder off at reset");
  hold_follow_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_b) locked_q |=> hold_en_q == $past(i_hold_enable))
    else $error("holder enable not followed");

  // Scenario covers: both locks, strobe use, keeper on and off
  host_lock_c: cover property (@(posedge i_core_clk)
    disable iff (!i_rst_b) $rose(locked_q) && func_q);
  gpio_lock_c: cover property (@(posedge i_core_clk)
    disable iff (!i_rst_b) $rose(locked_q) && !func_q);
  strobe_c: cover property (@(posedge i_core_clk)
    disable iff (!i_rst_b) o_host_address_strobe);
  hold_off_c: cover property (@(posedge i_core_clk)
    disable iff (!i_rst_b) locked_q && !hold_en_q);
  keep_hold_c: cover property (@(posedge i_core_clk)
    disable iff (!i_rst_b) locked_q && hold_en_q && sel_drv_w.data_oe == 0);

endmodule

// >>> tb/host_pin_partner.sv
// Purpose : Far-side model of the host data pins and control pin zero
// Assumes : A design drive wins wherever its enable is high
// Notes   : A released bit toggles, so a stale level never passes
`timescale 1ns/1ps
module host_pin_partner (
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_drv_en,
  input  wire logic [7:0] i_drv_val,
  input  wire logic       i_dut_ctl,
  input  wire logic       i_dut_ctl_oe,
  input  wire logic       i_ctl_val,
  input  wire logic [7:0] i_dut_val,
  input  wire logic [7:0] i_dut_oe,
  output logic      [7:0] o_pin_level,
  output logic            o_ctl_level
);
  logic [7:0] last_q;
  // ==========================================================
  // Wire resolution from the enables of both parties
  assign o_pin_level = (i_dut_oe & i_dut_val)
                     | (~i_dut_oe & i_drv_en & i_drv_val)
                     | (~i_dut_oe & ~i_drv_en & ~last_q);
  assign o_ctl_level = i_dut_ctl_oe ? i_dut_ctl : i_ctl_val;
  // Last level kept so a floating bit shows its inverse
  always_ff @(posedge i_core_clk) begin
    last_q <= o_pin_level;
  end
endmodule

// >>> tb/host_port_data_pin_mux_tb_top.sv
// Purpose : Self-checking bench for the host data pin mux
// Assumes : Pin-to-output latency of two edges, lock three after release
// Notes   : Expected levels come from a small wire model below
`timescale 1ns/1ps
module host_port_data_pin_mux_tb_top;
  logic       i_core_clk = 1'b0;
  logic       i_rst_b, boot, hold_en, ctl_val, cl, has, gp_stb, d_ctl;
  logic       d_ctl_oe, hmode, mmode, hact, ctl_lvl;
  logic [7:0] pin_en, pin_val, lvl, d_val, d_oe, gp_byte, hb, bt, pins;
  logic [7:0] q[$];
  int         errors = 0;
  int         comparisons = 0;
  host_pin_mux_pkg::pin_drive_s gdrv, hdrv, sel;
  // ==========================================================
  // Clock, design and far side
  always #2.5 i_core_clk = ~i_core_clk;
  host_port_data_pin_mux dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_boot_select_pin(boot), .i_hold_enable(hold_en),
    .i_host_data_pins(pins), .o_host_data_pins(d_val),
    .o_host_data_pins_oe(d_oe), .i_host_control_pin_zero(ctl_lvl),
    .o_host_control_pin_zero(d_ctl), .o_host_control_pin_zero_oe(d_ctl_oe),
    .i_gpio_drive(gdrv), .o_parallel_io_bits_high_byte(gp_byte),
    .o_parallel_io_bit_strobe_alt(gp_stb), .i_host_drive(hdrv),
    .o_host_bus_data(hb), .o_host_address_strobe(has),
    .o_host_mode(hmode), .o_mux_mode(mmode), .o_hold_active(hact));
  host_pin_partner far_end (.i_core_clk(i_core_clk), .i_drv_en(pin_en),
    .i_drv_val(pin_val), .i_dut_ctl(d_ctl), .i_dut_ctl_oe(d_ctl_oe),
    .i_ctl_val(ctl_val), .i_dut_val(d_val), .i_dut_oe(d_oe),
    .o_pin_level(pins), .o_ctl_level(ctl_lvl));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [7:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic conclude;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Strap wanders in reset; only its final value may count
  task automatic do_reset(input logic b);
    @(posedge i_core_clk);
    i_rst_b <= 1'b0;
    gdrv <= '0; // Functions come out of their own reset idle
    hdrv <= '0;
    repeat (13) begin
      @(posedge i_core_clk);
      boot <= 1'($urandom);
    end
    @(posedge i_core_clk);
    boot <= b;
    tick(4);
    chk("hold_rst", 8'h01, {7'h0, hact});
    chk("oe_rst", 8'hFF, d_oe);
    @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    tick(6);
    chk("mode", {7'h0, b}, {7'h0, hmode});
    chk("mux", {7'h0, b}, {7'h0, mmode});
    chk("oe_in", 8'h00, d_oe);
  endtask
  // ==========================================================
  // Watchdog, far longer than the sequence needs
  initial begin
    #5000;
    errors++;
    conclude();
  end
  // Main sequence: GPIO function, then host function
  initial begin
    i_rst_b = 1'b0;
    boot = 1'b0;
    hold_en = 1'b0;
    pin_en = 8'hFF;
    pin_val = 8'h00;
    ctl_val = 1'b0;
    gdrv = '0;
    hdrv = '0;
    void'($urandom(32'h55DF090E));
    for (int m = 0; m < 2; m++) begin
      do_reset(m[0]);
      for (int r = 0; r < 6; r++) begin
        @(posedge i_core_clk);
        boot <= ~m[0];
        pin_val <= 8'($urandom);
        ctl_val <= 1'($urandom);
        gdrv <= 18'($urandom);
        hdrv <= 18'($urandom);
        tick(3);
        sel = m[0] ? hdrv : gdrv;
        lvl = (sel.data_oe & sel.data_out) | (~sel.data_oe & pin_val);
        cl = (!m[0] && gdrv.ctl_oe) ? gdrv.ctl_out : ctl_val;
        chk("oe", sel.data_oe, d_oe);
        chk("val", sel.data_oe & sel.data_out, d_oe & d_val);
        chk("ctl_oe", {7'h0, !m[0] & gdrv.ctl_oe}, {7'h0, d_ctl_oe});
        chk("gpio", m[0] ? 8'h00 : lvl, gp_byte);
        chk("hbus", m[0] ? lvl : 8'h00, hb);
        chk("stb_alt", {7'h0, !m[0] && cl}, {7'h0, gp_stb});
        chk("has", {7'h0, m[0] && cl}, {7'h0, has});
        chk("kept", {7'h0, m[0]}, {7'h0, hmode});
      end
    end
    // Host cycle: first then second byte, back to back
    for (int k = 0; k < 2; k++) begin
      @(posedge i_core_clk);
      bt = 8'($urandom);
      q.push_back(bt);
      pin_val <= bt;
      hdrv <= '0;
      tick(3);
      chk("byte", q.pop_front(), hb);
    end
    // Keeper holds the last driven level once the drive stops
    @(posedge i_core_clk);
    hold_en <= 1'b1;
    hdrv <= 18'h297FC;
    tick(3);
    chk("hold_on", 8'h01, {7'h0, hact});
    @(posedge i_core_clk);
    hdrv <= '0;
    pin_en <= 8'h00; // Far side lets go too: only the keeper remains
    tick(3);
    chk("keep_oe", 8'hFF, d_oe);
    chk("keep_val", 8'hA5, d_val);
    chk("keep_pin", 8'hA5, hb);
    @(posedge i_core_clk);
    hold_en <= 1'b0;
    pin_en <= 8'hFF;
    tick(3);
    chk("hold_off", 8'h00, {7'h0, hact});
    chk("free_oe", 8'h00, d_oe);
    conclude();
  end
endmodule
